//--- hdl/cab_counter_array.v
// Counter array byte registers: counter, snapshot, compare and auto-reload bytes
`timescale 1ns/10ps
`include "cab_regs.vh"
module cab_counter_array (
  sys_clk,
  reset,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  count_en,
  auto_reload_select,
  watchdog_lock_enable,
  comparator_function_enable,
  counter_value,
  compare_match
);
  input  wire        sys_clk;
  input  wire        reset;
  input  wire [7:0]  reg_addr;
  input  wire        reg_wr;
  input  wire        reg_rd;
  input  wire [7:0]  reg_wdata;
  output reg  [7:0]  reg_rdata;
  input  wire        count_en;
  input  wire        auto_reload_select;
  input  wire        watchdog_lock_enable;
  output wire [5:0]  comparator_function_enable;
  output wire [15:0] counter_value;
  output reg  [5:0]  compare_match;

  reg  [15:0] counter_r;
  reg  [7:0]  snapshot_r;
  reg  [15:0] compare_r [0:5];
  reg  [15:0] reload_r  [0:5];
  reg  [5:0]  ecom_r;
  wire [2:0]  mod_idx;
  wire        is_high;
  wire        is_mod;
  wire        wr_cnt_lo;
  wire        wr_cnt_hi;
  wire        rd_cnt_lo;
  integer     i;
  integer     j;

  cab_addr_dec u_dec (
    .addr    (reg_addr),
    .mod_idx (mod_idx),
    .is_high (is_high),
    .is_mod  (is_mod)
  );

  assign wr_cnt_lo = reg_wr && (reg_addr == `CAB_ADDR_CNT_LOW) && !watchdog_lock_enable;
  assign wr_cnt_hi = reg_wr && (reg_addr == `CAB_ADDR_CNT_HIGH) && !watchdog_lock_enable;
  assign rd_cnt_lo = reg_rd && (reg_addr == `CAB_ADDR_CNT_LOW);
  assign counter_value = counter_r;
  assign comparator_function_enable = ecom_r;

  // Counter and snapshot; software writes take priority over counting
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      counter_r  <= `CAB_WORD_RESET;
      snapshot_r <= `CAB_BYTE_RESET;
    end else begin
      if (wr_cnt_lo || wr_cnt_hi) begin
        if (wr_cnt_lo)
          counter_r[7:0] <= reg_wdata;
        if (wr_cnt_hi)
          counter_r[15:8] <= reg_wdata;
      end else if (count_en) begin
        counter_r <= counter_r + `CAB_CNT_ONE;
      end
      if (rd_cnt_lo)
        snapshot_r <= counter_r[15:8];
    end
  end

  // Module bytes; the select bit picks compare or auto-reload storage
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ecom_r <= `CAB_ECOM_RESET;
      for (i = 0; i < `CAB_NMOD; i = i + 1) begin
        compare_r[i] <= `CAB_WORD_RESET;
        reload_r[i]  <= `CAB_WORD_RESET;
      end
    end else if (reg_wr && is_mod) begin
      if (is_high) begin
        if (auto_reload_select)
          reload_r[mod_idx][15:8] <= reg_wdata;
        else
          compare_r[mod_idx][15:8] <= reg_wdata;
        ecom_r[mod_idx] <= 1'b1;
      end else begin
        if (auto_reload_select)
          reload_r[mod_idx][7:0] <= reg_wdata;
        else
          compare_r[mod_idx][7:0] <= reg_wdata;
        ecom_r[mod_idx] <= 1'b0;
      end
    end
  end

  // Registered compare outputs, gated by each module's enable
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      compare_match <= `CAB_ECOM_RESET;
    end else begin
      for (j = 0; j < `CAB_NMOD; j = j + 1)
        compare_match[j] <= ecom_r[j] && (counter_r == compare_r[j]);
    end
  end

  // Read data; unmapped addresses return zero
  always @* begin
    reg_rdata = `CAB_BYTE_RESET;
    if (reg_addr == `CAB_ADDR_CNT_LOW)
      reg_rdata = counter_r[7:0];
    else if (reg_addr == `CAB_ADDR_CNT_HIGH)
      reg_rdata = snapshot_r;
    else if (is_mod) begin
      if (auto_reload_select)
        reg_rdata = is_high ? reload_r[mod_idx][15:8] : reload_r[mod_idx][7:0];
      else
        reg_rdata = is_high ? compare_r[mod_idx][15:8] : compare_r[mod_idx][7:0];
    end
  end
endmodule // cab_counter_array

//--- include/cab_regs.vh
// Register addresses, reset values and field constants of the counter array byte access block
// Function
// - Counter high byte exposes counter bits 15:8, read/write, reset zero.
// - High byte reads return a snapshot loaded only when the low byte is read.
// - Writes to counter high byte ignored while watchdog lock enable is 1.
// - Each of six modules has a low byte of compare value, reset zero.
// - Auto-reload select steers low byte address to compare or auto-reload low byte.
// - Any write to a module low byte clears its comparator function enable.
// - Each module has a high byte of compare value, read/write, reset zero.
// - Auto-reload select steers high byte address to compare or auto-reload high byte.
// - Any write to a module high byte sets its comparator function enable.
// - Counter low byte holds counter bits 7:0 at address F9, reset zero.
// - Comparator function enable at 1 enables that module's compare against counter.
`ifndef CAB_REGS_VH
`define CAB_REGS_VH
`define CAB_ADDR_CNT_LOW   8'hF9
`define CAB_ADDR_CNT_HIGH  8'hFA
`define CAB_ADDR_CPL0      8'hFB
`define CAB_ADDR_CPH0      8'hFC
`define CAB_ADDR_CPL1      8'hE9
`define CAB_ADDR_CPH1      8'hEA
`define CAB_ADDR_CPL2      8'hEB
`define CAB_ADDR_CPH2      8'hEC
`define CAB_ADDR_CPL3      8'hED
`define CAB_ADDR_CPH3      8'hEE
`define CAB_ADDR_CPL4      8'hFD
`define CAB_ADDR_CPH4      8'hFE
`define CAB_ADDR_CPL5      8'hD2
`define CAB_ADDR_CPH5      8'hD3
`define CAB_BYTE_RESET     8'h00
`define CAB_WORD_RESET     16'h0000
`define CAB_CNT_ONE        16'h0001
`define CAB_NMOD           6
`define CAB_MOD_NONE       3'h7
`define CAB_ECOM_RESET     6'h00
`endif

//--- hdl/cab_addr_dec.v
// Address decoder mapping a register address to a module index and byte kind
`timescale 1ns/10ps
`include "cab_regs.vh"
module cab_addr_dec (
  addr,
  mod_idx,
  is_high,
  is_mod
);
  input  wire [7:0] addr;
  output reg  [2:0] mod_idx;
  output reg        is_high;
  output reg        is_mod;

  always @* begin
    mod_idx = `CAB_MOD_NONE;
    is_high = 1'b0;
    is_mod  = 1'b1;
    case (addr)
      `CAB_ADDR_CPL0: mod_idx = 3'h0;
      `CAB_ADDR_CPH0: begin mod_idx = 3'h0; is_high = 1'b1; end
      `CAB_ADDR_CPL1: mod_idx = 3'h1;
      `CAB_ADDR_CPH1: begin mod_idx = 3'h1; is_high = 1'b1; end
      `CAB_ADDR_CPL2: mod_idx = 3'h2;
      `CAB_ADDR_CPH2: begin mod_idx = 3'h2; is_high = 1'b1; end
      `CAB_ADDR_CPL3: mod_idx = 3'h3;
      `CAB_ADDR_CPH3: begin mod_idx = 3'h3; is_high = 1'b1; end
      `CAB_ADDR_CPL4: mod_idx = 3'h4;
      `CAB_ADDR_CPH4: begin mod_idx = 3'h4; is_high = 1'b1; end
      `CAB_ADDR_CPL5: mod_idx = 3'h5;
      `CAB_ADDR_CPH5: begin mod_idx = 3'h5; is_high = 1'b1; end
      default:        is_mod = 1'b0;
    endcase
  end
endmodule // cab_addr_dec

//--- tb/cab_counter_array_chk.sv
// Port assertions for the counter array byte registers
`timescale 1ns/10ps
module cab_counter_array_chk (
  input wire        sys_clk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        count_en,
  input wire        watchdog_lock_enable,
  input wire [5:0]  comparator_function_enable,
  input wire [15:0] counter_value,
  input wire [5:0]  compare_match
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire      wr_ok = reg_wr && !watchdog_lock_enable;
  reg [7:0] snap_r;
  // Expected snapshot, loaded only by a low byte read
  always @(posedge sys_clk or posedge reset)
    if (reset) snap_r <= 8'h00;
    else if (reg_rd && reg_addr == 8'hF9) snap_r <= counter_value[15:8];
  a_high_wr_lands: assert property (wr_ok && reg_addr == 8'hFA |=>
    counter_value[15:8] == $past(reg_wdata)) else $error("high byte write lost");
  a_low_wr_lands: assert property (wr_ok && reg_addr == 8'hF9 |=>
    counter_value[7:0] == $past(reg_wdata)) else $error("low byte write lost");
  a_lock_blocks_wr: assert property (reg_wr && watchdog_lock_enable && !count_en &&
    (reg_addr == 8'hFA || reg_addr == 8'hF9) |=> $stable(counter_value)) else $error("locked write");
  a_snap_read: assert property (reg_addr == 8'hFA |-> reg_rdata == snap_r)
    else $error("snapshot read wrong");
  a_low_read: assert property (reg_addr == 8'hF9 |-> reg_rdata == counter_value[7:0])
    else $error("low byte read wrong");
  a_low_clears_en: assert property (reg_wr && reg_addr == 8'hFB |=>
    !comparator_function_enable[0]) else $error("enable not cleared");
  a_high_sets_en: assert property (reg_wr && reg_addr == 8'hFC |=>
    comparator_function_enable[0]) else $error("enable not set");
  a_en_holds: assert property (!reg_wr |=> $stable(comparator_function_enable))
    else $error("enable moved");
  a_off_no_match: assert property (comparator_function_enable == 6'h00 |=>
    compare_match == 6'h00) else $error("match while disabled");
  a_count_step: assert property (count_en && !reg_wr |=>
    counter_value == $past(counter_value) + 16'h0001) else $error("count step wrong");
endmodule // cab_counter_array_chk
bind cab_counter_array cab_counter_array_chk i_chk (.*);

//--- tb/tb_counter_array_byte_access.sv
// Self-checking bench for the counter array byte registers
`timescale 1ns/10ps
module tb_counter_array_byte_access;
  localparam [95:0] AT = 96'hFBFCE9EAEBECEDEEFDFED2D3;
  reg         sys_clk, reset, reg_wr, reg_rd, count_en, auto_reload_select, watchdog_lock_enable;
  reg  [7:0]  reg_addr, reg_wdata, d, h;
  reg  [7:0]  mdl [0:23];
  reg  [15:0] e;
  wire [7:0]  reg_rdata;
  wire [5:0]  en, cm;
  wire [15:0] cv;
  integer     num_errors, cmp_count, cyc, k;
  cab_counter_array i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .count_en(count_en), .auto_reload_select(auto_reload_select),
    .watchdog_lock_enable(watchdog_lock_enable), .comparator_function_enable(en),
    .counter_value(cv), .compare_match(cm));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function [7:0] mod_addr(input integer i);
    mod_addr = AT[8*(11-i%12) +: 8];
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input [7:0] ad);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    d = reg_rdata;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  initial begin
    {reset, reg_wr, reg_rd, count_en, auto_reload_select, watchdog_lock_enable} = 6'h20;
    {reg_addr, reg_wdata, num_errors, cmp_count, cyc} = 0;
    k = $urandom(32'h330C);
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (k = 0; k < 27; k = k + 1) begin
      auto_reload_select <= (k >= 12);
      rd((k < 24) ? mod_addr(k) : (k == 24) ? 8'hF9 : (k == 25) ? 8'hFA : 8'h80);
      chk(d, 8'h00);
    end
    $display("test reset values done");
    for (k = 0; k < 48; k = k + 1) begin
      auto_reload_select <= (k % 24 >= 12);
      if (k < 24) mdl[k] = $urandom;
      if (k < 24) wr(mod_addr(k), mdl[k]);
      if (k < 24) chk({7'h00, en[(k%12)/2]}, {7'h00, k[0]});
      else rd(mod_addr(k));
      if (k >= 24) chk(d, mdl[k-24]);
    end
    $display("test module bytes done");
    watchdog_lock_enable <= 1'b1;
    wr(8'hFA, 8'h5A);
    wr(8'hF9, 8'hA5);
    rd(8'hF9);
    chk(d, 8'h00);
    watchdog_lock_enable <= 1'b0;
    h = $urandom;
    wr(8'hFA, h);
    wr(8'hF9, 8'hFF);
    rd(8'hF9);
    chk(d, 8'hFF);
    wr(8'hFA, ~h);
    rd(8'hFA);
    chk(d, h);
    e = {~h, 8'hFF} + 16'd300;
    count_en <= 1'b1;
    repeat (300) @(posedge sys_clk);
    count_en <= 1'b0;
    rd(8'hF9);
    chk(d, e[7:0]);
    rd(8'hFA);
    chk(d, e[15:8]);
    $display("test counter done");
    auto_reload_select <= 1'b0;
    e = e + 16'h0008;
    wr(8'hFB, e[7:0]);
    wr(8'hFC, e[15:8]);
    chk({7'h00, cm[0]}, 8'h00);
    count_en <= 1'b1;
    repeat (8) @(posedge sys_clk);
    count_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({7'h00, cm[0]}, 8'h01);
    $display("test compare match done");
    wrap_up;
  end
endmodule // tb_counter_array_byte_access
